// file: chf_pkg.sv
// Package: register map, field positions, reset values and carriers
`default_nettype none
package chf_pkg;

    localparam logic [7:0] CHF_ADDR_CMD       = 8'h00;
    localparam logic [7:0] CHF_ADDR_HOST_CTRL = 8'h01;
    localparam logic [7:0] CHF_ADDR_QCTRL     = 8'h02;
    localparam logic [7:0] CHF_ADDR_QTHR      = 8'h03;
    localparam logic [7:0] CHF_ADDR_QFILL     = 8'h04;
    localparam logic [7:0] CHF_ADDR_QDATA     = 8'h05;

    localparam int CHF_CMD_STANDBY_BIT   = 7;
    localparam int CHF_CMD_RF_OFF_BIT    = 6;
    localparam int CHF_CMD_CODE_MSB      = 4;

    localparam int CHF_HC_UNLOCK_BIT     = 7;
    localparam int CHF_HC_HOST_BIT       = 6;
    localparam int CHF_HC_MODULE_BIT     = 5;
    localparam int CHF_HC_IF_MSB         = 3;
    localparam int CHF_HC_IF_LSB         = 2;

    localparam int CHF_QC_DEPTH_BIT      = 7;
    localparam int CHF_QC_NFULL_BIT      = 6;
    localparam int CHF_QC_NEMPTY_BIT     = 5;
    localparam int CHF_QC_CLEAR_BIT      = 4;
    localparam int CHF_QC_THR_MSB_BIT    = 2;

    localparam int CHF_CNT_W             = 10;
    localparam logic [9:0] CHF_CAP_SMALL = 10'h0ff;
    localparam logic [9:0] CHF_CAP_LARGE = 10'h200;

    localparam logic [7:0] CHF_RST_CMD       = 8'h00;
    localparam logic [7:0] CHF_RST_HOST_CTRL = 8'h00;
    localparam logic       CHF_RST_DEPTH     = 1'b0;
    localparam logic       CHF_RST_THR_MSB   = 1'b0;
    localparam logic [7:0] CHF_RST_THR       = 8'h00;

    typedef enum logic [3:0] {
        CHF_IF_OFF     = 4'b0001,
        CHF_IF_SPI     = 4'b0010,
        CHF_IF_TWO_RED = 4'b0100,
        CHF_IF_I2C     = 4'b1000
    } chf_if_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } chf_req_t;

    typedef struct packed {
        logic       host;
        logic       module_sel;
        logic [1:0] if_sel;
    } chf_own_t;

endpackage
`default_nettype wire

// file: chf_host_ctrl.sv
// Host bus control register with unlock and ownership arbitration
`timescale 1ns/1ns
`default_nettype none
module chf_host_ctrl (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             any_wr,
    input  wire logic             hc_wr,
    input  wire logic [7:0]       wdata,
    output logic                  unlock_q,
    output chf_pkg::chf_own_t     own_q
);
    import chf_pkg::*;

    logic       both_req;
    logic       host_q;
    logic       mod_q;
    logic [1:0] if_q;

    assign both_req = wdata[CHF_HC_HOST_BIT] & wdata[CHF_HC_MODULE_BIT];
    assign own_q    = '{host: host_q, module_sel: mod_q, if_sel: if_q};

    // R4 unlock set and auto clear
    always_ff @(posedge clk) begin
        if (srst) begin
            unlock_q <= CHF_RST_HOST_CTRL[CHF_HC_UNLOCK_BIT];
        end else if (ce && any_wr) begin
            unlock_q <= !unlock_q && hc_wr && wdata[CHF_HC_UNLOCK_BIT];
        end
    end

    // R5 R6 R18 guarded ownership
    always_ff @(posedge clk) begin
        if (srst) begin
            host_q <= CHF_RST_HOST_CTRL[CHF_HC_HOST_BIT];
            mod_q  <= CHF_RST_HOST_CTRL[CHF_HC_MODULE_BIT];
        end else if (ce && hc_wr && unlock_q && !both_req) begin
            host_q <= wdata[CHF_HC_HOST_BIT];
            mod_q  <= wdata[CHF_HC_MODULE_BIT];
        end
    end

    // R7 interface select update
    always_ff @(posedge clk) begin
        if (srst) begin
            if_q <= CHF_RST_HOST_CTRL[CHF_HC_IF_MSB:CHF_HC_IF_LSB];
        end else if (ce && hc_wr && unlock_q) begin
            if_q <= wdata[CHF_HC_IF_MSB:CHF_HC_IF_LSB];
        end
    end

    AST_OWN_EXCL: assert property (@(posedge clk) disable iff (srst) // R5
        !(own_q.host && own_q.module_sel))
        else $error("Both bus owners selected");

    AST_UNLOCK_AUTO_CLEAR: assert property (@(posedge clk) // R4
        disable iff (srst)
        (ce && any_wr && unlock_q) |=> !unlock_q)
        else $error("Unlock not cleared by write");

    AST_LOCKED_OWN_HOLD: assert property (@(posedge clk) // R18
        disable iff (srst)
        (ce && hc_wr && (!unlock_q || both_req))
        |=> ($stable(own_q.host) && $stable(own_q.module_sel)))
        else $error("Ownership changed without valid unlock");

endmodule
`default_nettype wire

// file: chf_fill_count.sv
// Queue byte counter with near-full and near-empty alerts
`timescale 1ns/1ns
`default_nettype none
module chf_fill_count #(
    parameter int CNT_W = 10
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic             clear,
    input  wire logic             depth_small,
    input  wire logic [8:0]       thr,
    output logic [CNT_W-1:0]      count_q,
    output logic                  near_full,
    output logic                  near_empty
);
    import chf_pkg::*;

    logic [CNT_W-1:0] cap;
    logic [CNT_W-1:0] thr_eff;
    logic             can_push;
    logic             can_pop;

    // R8 capacity from depth select
    assign cap = depth_small ? CNT_W'(CHF_CAP_SMALL) : CNT_W'(CHF_CAP_LARGE);
    // R13 R15 extension bit only in large mode
    assign thr_eff = depth_small ? CNT_W'(thr[7:0]) : CNT_W'(thr);
    assign can_push = push && (count_q < cap);
    assign can_pop  = pop && (count_q != '0);

    // R12 R16 count update, clear wins
    always_ff @(posedge clk) begin
        if (srst) begin
            count_q <= '0;
        end else if (ce) begin
            if (clear) begin
                count_q <= '0;
            end else if (can_push && !can_pop) begin
                count_q <= count_q + CNT_W'(1);
            end else if (can_pop && !can_push) begin
                count_q <= count_q - CNT_W'(1);
            end
        end
    end

    // R10 R11 alert compare
    assign near_full  = (cap - count_q) <= thr_eff;
    assign near_empty = count_q <= thr_eff;

    AST_CLEAR_EMPTIES: assert property (@(posedge clk) disable iff (srst) // R12
        (ce && clear) |=> (count_q == '0))
        else $error("Clear did not empty the queue");

    AST_PUSH_INC: assert property (@(posedge clk) disable iff (srst) // R16
        (ce && !clear && can_push && !pop) |=> (count_q == $past(count_q) + 1))
        else $error("Push did not increment count");

    AST_POP_DEC: assert property (@(posedge clk) disable iff (srst) // R16
        (ce && !clear && can_pop && !push) |=> (count_q == $past(count_q) - 1))
        else $error("Pop did not decrement count");

    AST_NEAR_EMPTY: assert property (@(posedge clk) disable iff (srst) // R11
        (count_q == '0) |-> near_empty)
        else $error("Empty queue without near-empty alert");

endmodule
`default_nettype wire

// file: chf_regs.sv
// Command, host control and queue configuration register front
// What this block does
// R1 - Writing 1 to command bit 7 enters power-down.
// R2 - Command bit 6 set powers down receiver and transmitter; read/write.
// R3 - Command bits 4..0 hold running command; write starts, device may update.
// R4 - Host control unlock bit 7 allows next change; next write clears it.
// R5 - Host ownership bit 6 set only after unlock, never with module bit.
// R6 - Module ownership bit 5 set only after unlock, never with host bit.
// R7 - Interface select bits 3..2: off, SPI, reduced two-wire, full I2C.
// R8 - Queue control bit 7: 1 gives 255 bytes, 0 gives 512.
// R9 - Host should change capacity only after the queue is cleared.
// R10 - Near-full bit 6 reads 1 when capacity minus count <= threshold.
// R11 - Near-empty bit 5 reads 1 when count <= threshold.
// R12 - Writing 1 to bit 4 empties the queue; bit reads 0.
// R13 - Queue control bit 2 is threshold bit 8, used in 512 mode only.
// R14 - Queue control bits 1..0 report count bits 9 and 8.
// R15 - Threshold register holds alert level bits 7..0 for both compares.
// R16 - Count rises on each data port write, falls on each read; the counter holds at capacity on a write and at 0 on a read.
// R17 - Reserved bits read 0 and ignore writes.
// R18 - Double ownership or unlocked-less write leaves ownership unchanged.
`timescale 1ns/1ns
`default_nettype none
module chf_regs #(
    parameter int CNT_W = 10
) (
    input  wire logic                MCLK,
    input  wire logic                SRST,
    input  wire logic                CE,
    input  wire chf_pkg::chf_req_t   REG_REQ,
    output logic [7:0]               REG_RDATA,
    output logic                     REG_RVALID,
    input  wire logic                CMD_UPDATE,
    input  wire logic [4:0]          CMD_NEXT,
    output logic                     CMD_START,
    output logic [4:0]               CMD_CODE,
    output logic                     POWER_DOWN,
    output logic                     RF_FRONTEND_OFF,
    output logic                     BUS_OWNER_HOST,
    output logic                     BUS_OWNER_MODULE,
    output chf_pkg::chf_if_t         SM_IF_MODE,
    output logic                     QUEUE_PUSH,
    output logic                     QUEUE_POP,
    output logic [7:0]               QUEUE_WDATA,
    input  wire logic [7:0]          QUEUE_RDATA,
    output logic                     QUEUE_CLEAR,
    output logic [CNT_W-1:0]         FILL_COUNT,
    output logic                     NEAR_FULL,
    output logic                     NEAR_EMPTY
);
    import chf_pkg::*;

    logic             wr_cmd;
    logic             wr_hc;
    logic             wr_qc;
    logic             wr_thr;
    logic             wr_data;
    logic             rd_data;
    logic             standby_q;
    logic             rf_off_q;
    logic [4:0]       cmd_q;
    logic             cmd_start_q;
    logic             depth_small_q;
    logic             thr_msb_q;
    logic [7:0]       thr_q;
    logic             push_q;
    logic             pop_q;
    logic             clear_q;
    logic [7:0]       qwdata_q;
    logic [7:0]       rdata_q;
    logic [7:0]       rdata_d;
    logic             rvalid_q;
    logic             unlock_q;
    chf_own_t         own_q;
    logic [CNT_W-1:0] count_q;
    logic             near_full;
    logic             near_empty;
    chf_if_t          if_mode;

    function automatic logic hit(input chf_req_t r, input logic [7:0] a);
        hit = r.addr == a;
    endfunction

    assign wr_cmd  = REG_REQ.wr && hit(REG_REQ, CHF_ADDR_CMD);
    assign wr_hc   = REG_REQ.wr && hit(REG_REQ, CHF_ADDR_HOST_CTRL);
    assign wr_qc   = REG_REQ.wr && hit(REG_REQ, CHF_ADDR_QCTRL);
    assign wr_thr  = REG_REQ.wr && hit(REG_REQ, CHF_ADDR_QTHR);
    assign wr_data = REG_REQ.wr && hit(REG_REQ, CHF_ADDR_QDATA);
    assign rd_data = REG_REQ.rd && !REG_REQ.wr
                     && hit(REG_REQ, CHF_ADDR_QDATA);

    // R1 power-down bit
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            standby_q <= CHF_RST_CMD[CHF_CMD_STANDBY_BIT];
        end else if (CE && wr_cmd) begin
            standby_q <= REG_REQ.wdata[CHF_CMD_STANDBY_BIT];
        end
    end

    // R2 front end off bit
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rf_off_q <= CHF_RST_CMD[CHF_CMD_RF_OFF_BIT];
        end else if (CE && wr_cmd) begin
            rf_off_q <= REG_REQ.wdata[CHF_CMD_RF_OFF_BIT];
        end
    end

    // R3 command field, host write wins
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            cmd_q       <= CHF_RST_CMD[CHF_CMD_CODE_MSB:0];
            cmd_start_q <= 1'b0;
        end else if (CE) begin
            cmd_start_q <= wr_cmd;
            if (wr_cmd) begin
                cmd_q <= REG_REQ.wdata[CHF_CMD_CODE_MSB:0];
            end else if (CMD_UPDATE) begin
                cmd_q <= CMD_NEXT;
            end
        end
    end

    chf_host_ctrl u_host_ctrl (
        .clk      (MCLK),
        .srst     (SRST),
        .ce       (CE),
        .any_wr   (REG_REQ.wr),
        .hc_wr    (wr_hc),
        .wdata    (REG_REQ.wdata),
        .unlock_q (unlock_q),
        .own_q    (own_q)
    );

    // R7 interface mode decode
    always_comb begin
        case (own_q.if_sel)
            2'h0: if_mode = CHF_IF_OFF;
            2'h1: if_mode = CHF_IF_SPI;
            2'h2: if_mode = CHF_IF_TWO_RED;
            2'h3: if_mode = CHF_IF_I2C;
            default: if_mode = CHF_IF_OFF;
        endcase
    end

    // R8 R13 queue control writable fields
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            depth_small_q <= CHF_RST_DEPTH;
            thr_msb_q     <= CHF_RST_THR_MSB;
        end else if (CE && wr_qc) begin
            depth_small_q <= REG_REQ.wdata[CHF_QC_DEPTH_BIT];
            thr_msb_q     <= REG_REQ.wdata[CHF_QC_THR_MSB_BIT];
        end
    end

    // R15 threshold register
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            thr_q <= CHF_RST_THR;
        end else if (CE && wr_thr) begin
            thr_q <= REG_REQ.wdata;
        end
    end

    // R12 R16 queue strobes to the data store
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            push_q   <= 1'b0;
            pop_q    <= 1'b0;
            clear_q  <= 1'b0;
            qwdata_q <= 8'h00;
        end else if (CE) begin
            push_q  <= wr_data;
            pop_q   <= rd_data;
            clear_q <= wr_qc && REG_REQ.wdata[CHF_QC_CLEAR_BIT];
            if (wr_data) begin
                qwdata_q <= REG_REQ.wdata;
            end
        end
    end

    chf_fill_count #(
        .CNT_W (CNT_W)
    ) u_fill_count (
        .clk         (MCLK),
        .srst        (SRST),
        .ce          (CE),
        .push        (wr_data),
        .pop         (rd_data),
        .clear       (wr_qc && REG_REQ.wdata[CHF_QC_CLEAR_BIT]),
        .depth_small (depth_small_q),
        .thr         ({thr_msb_q, thr_q}),
        .count_q     (count_q),
        .near_full   (near_full),
        .near_empty  (near_empty)
    );

    // R17 read mux, reserved and unmapped read 0
    always_comb begin
        rdata_d = 8'h00;
        case (REG_REQ.addr)
            CHF_ADDR_CMD: begin
                rdata_d[CHF_CMD_STANDBY_BIT]      = standby_q;
                rdata_d[CHF_CMD_RF_OFF_BIT]       = rf_off_q;
                rdata_d[CHF_CMD_CODE_MSB:0]       = cmd_q;
            end
            CHF_ADDR_HOST_CTRL: begin
                rdata_d[CHF_HC_UNLOCK_BIT]        = unlock_q;
                rdata_d[CHF_HC_HOST_BIT]          = own_q.host;
                rdata_d[CHF_HC_MODULE_BIT]        = own_q.module_sel;
                rdata_d[CHF_HC_IF_MSB:CHF_HC_IF_LSB] = own_q.if_sel;
            end
            // R10 R11 R12 R14 queue control readback
            CHF_ADDR_QCTRL: begin
                rdata_d[CHF_QC_DEPTH_BIT]         = depth_small_q;
                rdata_d[CHF_QC_NFULL_BIT]         = near_full;
                rdata_d[CHF_QC_NEMPTY_BIT]        = near_empty;
                rdata_d[CHF_QC_THR_MSB_BIT]       = thr_msb_q;
                rdata_d[1:0]                      = count_q[9:8];
            end
            CHF_ADDR_QTHR: begin
                rdata_d = thr_q;
            end
            CHF_ADDR_QFILL: begin
                rdata_d = count_q[7:0];
            end
            CHF_ADDR_QDATA: begin
                rdata_d = QUEUE_RDATA;
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else if (CE) begin
            rvalid_q <= REG_REQ.rd && !REG_REQ.wr;
            if (REG_REQ.rd && !REG_REQ.wr) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign REG_RDATA        = rdata_q;
    assign REG_RVALID       = rvalid_q;
    assign CMD_START        = cmd_start_q;
    assign CMD_CODE         = cmd_q;
    assign POWER_DOWN       = standby_q;
    assign RF_FRONTEND_OFF  = rf_off_q;
    assign BUS_OWNER_HOST   = own_q.host;
    assign BUS_OWNER_MODULE = own_q.module_sel;
    assign SM_IF_MODE       = if_mode;
    assign QUEUE_PUSH       = push_q;
    assign QUEUE_POP        = pop_q;
    assign QUEUE_WDATA      = qwdata_q;
    assign QUEUE_CLEAR      = clear_q;
    assign FILL_COUNT       = count_q;
    assign NEAR_FULL        = near_full;
    assign NEAR_EMPTY       = near_empty;

    AST_STANDBY_WRITE: assert property (@(posedge MCLK) disable iff (SRST) // R1
        (CE && wr_cmd && REG_REQ.wdata[7]) |=> POWER_DOWN)
        else $error("Power-down not entered");

    AST_RF_OFF_WRITE: assert property (@(posedge MCLK) disable iff (SRST) // R2
        (CE && wr_cmd) |=> (RF_FRONTEND_OFF == $past(REG_REQ.wdata[6])))
        else $error("Front end off bit not stored");

    AST_CMD_START: assert property (@(posedge MCLK) disable iff (SRST) // R3
        (CE && wr_cmd) |=> (CMD_START && CMD_CODE == $past(REG_REQ.wdata[4:0])))
        else $error("Command write did not start command");

    AST_CLEAR_READS_ZERO: assert property (@(posedge MCLK) // R12
        disable iff (SRST)
        (CE && REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == CHF_ADDR_QCTRL)
        |=> (REG_RVALID && REG_RDATA[4:3] == 2'b00))
        else $error("Write-only or reserved queue bits read nonzero");

    AST_NEAR_FULL_CMP: assert property (@(posedge MCLK) disable iff (SRST) // R10
        (depth_small_q && (10'h0ff - count_q) <= {2'b00, thr_q}) |-> NEAR_FULL)
        else $error("Near-full alert missing");

    AST_HC_RSVD_ZERO: assert property (@(posedge MCLK) disable iff (SRST) // R17
        (CE && REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == CHF_ADDR_HOST_CTRL)
        |=> (REG_RDATA[4] == 1'b0 && REG_RDATA[1:0] == 2'b00))
        else $error("Reserved host control bits read nonzero");

    AST_CLEAR_PULSE: assert property (@(posedge MCLK) // R12
        disable iff (SRST)
        (CE && wr_qc && REG_REQ.wdata[CHF_QC_CLEAR_BIT]) |=> QUEUE_CLEAR)
        else $error("Clear write gave no clear pulse");

    AST_COUNT_MSBS_READ: assert property (@(posedge MCLK) // R14
        disable iff (SRST)
        (CE && REG_REQ.rd && !REG_REQ.wr && REG_REQ.addr == CHF_ADDR_QCTRL)
        |=> (REG_RDATA[1:0] == $past(count_q[9:8])))
        else $error("Count high bits not reported");

    AST_THR_STORE: assert property (@(posedge MCLK) // R15
        disable iff (SRST)
        (CE && wr_thr) |=> (thr_q == $past(REG_REQ.wdata)))
        else $error("Threshold write not stored");

endmodule
`default_nettype wire

// file: chf_host_model.sv
// Host side model: issues register reads and writes
`timescale 1ns/1ns
`default_nettype none
module chf_host_model (
    input  wire logic         MCLK,
    output chf_pkg::chf_req_t REG_REQ
);
    import chf_pkg::*;

    initial REG_REQ = '0;

    // One request held until its taking edge, then released
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(posedge MCLK);
        REG_REQ <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge MCLK);
        REG_REQ <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask
endmodule
`default_nettype wire

// file: chf_regs_bench.sv
// Self-checking bench for the register front
`timescale 1ns/1ns
`default_nettype none
module chf_regs_bench;
    import chf_pkg::*;

    logic             MCLK = 1'b0;
    logic             srst = 1'b1;
    logic             ce = 1'b1;
    logic             cmd_upd = 1'b0;
    logic [4:0]       cmd_nxt = 5'h00;
    logic [7:0]       qrd = 8'h00;
    chf_req_t         req;
    logic [7:0]       rdata, qwdata;
    logic             rvalid, cstart, pd, rfoff, oh, om, push, pop, qclr;
    logic             nfl, nem;
    logic [4:0]       ccode;
    chf_if_t          ifm;
    logic [9:0]       fcnt;
    logic [7:0]       s_cmd, s_thr;
    logic             s_unl, s_host, s_mod, s_dep, s_tmsb;
    logic [1:0]       s_if;
    logic [9:0]       s_cnt;
    logic [7:0]       eq[$], wq[$];
    int               fails = 0, num_checks = 0;
    int               n_cmd = 0, n_clr = 0, n_pop = 0;
    int               m_cmd = 0, m_clr = 0, m_pop = 0;

    always #4 MCLK = ~MCLK;

    chf_host_model host (.MCLK(MCLK), .REG_REQ(req));

    chf_regs #(.CNT_W(CHF_CNT_W)) uut (
        .MCLK(MCLK), .SRST(srst), .CE(ce), .REG_REQ(req),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .CMD_UPDATE(cmd_upd),
        .CMD_NEXT(cmd_nxt), .CMD_START(cstart), .CMD_CODE(ccode),
        .POWER_DOWN(pd), .RF_FRONTEND_OFF(rfoff), .BUS_OWNER_HOST(oh),
        .BUS_OWNER_MODULE(om), .SM_IF_MODE(ifm), .QUEUE_PUSH(push),
        .QUEUE_POP(pop), .QUEUE_WDATA(qwdata), .QUEUE_RDATA(qrd),
        .QUEUE_CLEAR(qclr), .FILL_COUNT(fcnt), .NEAR_FULL(nfl),
        .NEAR_EMPTY(nem));

    task automatic check(input string n, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    function automatic logic [9:0] cap();
        return s_dep ? CHF_CAP_SMALL : CHF_CAP_LARGE;
    endfunction

    // threshold msb only in 512 mode
    function automatic logic [9:0] thr_e();
        return s_dep ? {2'b00, s_thr} : {1'b0, s_tmsb, s_thr};
    endfunction

    function automatic logic nfull();
        return (cap() - s_cnt) <= thr_e();
    endfunction

    function automatic logic [7:0] rexp(input logic [7:0] a);
        case (a)
            CHF_ADDR_CMD:       return s_cmd;
            CHF_ADDR_HOST_CTRL: return {s_unl, s_host, s_mod, 1'b0, s_if,
                                        2'b00};
            CHF_ADDR_QCTRL:     return {s_dep, nfull(), s_cnt <= thr_e(),
                                        2'b00, s_tmsb, s_cnt[9:8]};
            CHF_ADDR_QTHR:      return s_thr;
            CHF_ADDR_QFILL:     return s_cnt[7:0];
            CHF_ADDR_QDATA:     return qrd;
            default:            return 8'h00;
        endcase
    endfunction

    task automatic lv();
        check("POWER_DOWN", 16'(pd), 16'(s_cmd[7]));
        check("RF_OFF", 16'(rfoff), 16'(s_cmd[6]));
        check("CMD_CODE", 16'(ccode), 16'(s_cmd[4:0]));
        check("OWN_HOST", 16'(oh), 16'(s_host));
        check("OWN_MOD", 16'(om), 16'(s_mod));
        check("IF_MODE", 16'(ifm), 16'(4'b0001 << s_if));
        check("FILL", 16'(fcnt), 16'(s_cnt));
        check("NFULL", 16'(nfl), 16'(nfull()));
        check("NEMPTY", 16'(nem), 16'(s_cnt <= thr_e()));
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic nu;
        host.xfer(1'b1, a, d);
        nu = (a == CHF_ADDR_HOST_CTRL) && !s_unl && d[7];
        // ownership moves only after unlock, never both
        if (a == CHF_ADDR_HOST_CTRL && s_unl) begin
            if (!(d[6] && d[5])) begin
                s_host = d[6];
                s_mod = d[5];
            end
            s_if = d[3:2];
        end
        s_unl = nu;
        case (a)
            CHF_ADDR_CMD: begin
                s_cmd = d & 8'hdf;
                n_cmd++;
            end
            CHF_ADDR_QCTRL: begin
                s_dep = d[7];
                s_tmsb = d[2];
                if (d[4]) s_cnt = '0;
                n_clr += 32'(d[4]);
            end
            CHF_ADDR_QTHR: s_thr = d;
            CHF_ADDR_QDATA: begin
                wq.push_back(d);
                if (s_cnt < cap()) s_cnt++;
            end
            default: ;
        endcase
        lv();
    endtask

    task automatic rd(input logic [7:0] a);
        if (a == CHF_ADDR_QDATA) begin
            @(posedge MCLK);
            qrd <= 8'($urandom);
            #1;
        end
        eq.push_back(rexp(a));
        host.xfer(1'b0, a, 8'h00);
        if (a == CHF_ADDR_QDATA) begin
            n_pop++;
            if (s_cnt != 0) s_cnt--;
        end
        lv();
    endtask

    task automatic do_reset();
        @(posedge MCLK);
        srst <= 1'b1;
        repeat (20) @(posedge MCLK);
        srst <= 1'b0;
        {s_cmd, s_thr, s_unl, s_host, s_mod, s_dep, s_tmsb} = '0;
        s_if = '0;
        s_cnt = '0;
        @(posedge MCLK);
        #1;
        lv();
    endtask

    always @(negedge MCLK) begin
        if (rvalid === 1'b1) begin
            if (eq.size() == 0) check("RVALID", 16'h1, 16'h0);
            else check("RDATA", 16'(rdata), 16'(eq.pop_front()));
        end
        if (push === 1'b1) begin
            check("WDATA", 16'(qwdata),
                  wq.size() > 0 ? 16'(wq.pop_front()) : 16'hffff);
        end
        if (cstart === 1'b1) m_cmd++;
        if (qclr === 1'b1) m_clr++;
        if (pop === 1'b1) m_pop++;
    end

    initial begin
        repeat (100000) @(posedge MCLK);
        fails++;
        give_verdict();
    end

    initial begin
        logic [4:0] nx;
        void'($urandom(32'h2b65c361));
        do_reset();
        for (int a = 0; a < 8; a++) rd(8'(a));
        rd(8'h80);
        for (int i = 0; i < 32; i++) begin
            wr(CHF_ADDR_CMD, {2'($urandom), 1'($urandom), 5'(i)});
        end
        rd(CHF_ADDR_CMD);
        nx = 5'($urandom);
        @(posedge MCLK);
        cmd_upd <= 1'b1;
        cmd_nxt <= nx;
        @(posedge MCLK);
        cmd_upd <= 1'b0;
        s_cmd[4:0] = nx;
        #1;
        lv();
        // locked write, then both owners at once
        wr(CHF_ADDR_HOST_CTRL, 8'h6c);
        wr(CHF_ADDR_HOST_CTRL, 8'h80);
        rd(CHF_ADDR_HOST_CTRL);
        wr(CHF_ADDR_HOST_CTRL, 8'h6c);
        for (int m = 0; m < 4; m++) begin
            wr(CHF_ADDR_HOST_CTRL, 8'h80);
            wr(CHF_ADDR_HOST_CTRL, {1'b0, m[0], !m[0], 1'b1, 2'(m), 2'b11});
            rd(CHF_ADDR_HOST_CTRL);
        end
        wr(CHF_ADDR_HOST_CTRL, 8'h80);
        wr(CHF_ADDR_QTHR, 8'($urandom));
        wr(CHF_ADDR_HOST_CTRL, 8'h40);
        // capacity changed together with a clear
        wr(CHF_ADDR_QCTRL, 8'h9b);
        repeat (257) wr(CHF_ADDR_QDATA, 8'($urandom));
        rd(CHF_ADDR_QCTRL);
        repeat (257) rd(CHF_ADDR_QDATA);
        wr(CHF_ADDR_QCTRL, 8'h14);
        wr(CHF_ADDR_QTHR, 8'h10);
        repeat (520) begin
            wr(CHF_ADDR_QDATA, 8'($urandom));
            rd(CHF_ADDR_QCTRL);
        end
        wr(CHF_ADDR_QCTRL, 8'h94);
        repeat (20) wr(CHF_ADDR_QDATA, 8'($urandom));
        wr(CHF_ADDR_QCTRL, 8'h10);
        rd(CHF_ADDR_QCTRL);
        @(posedge MCLK);
        ce <= 1'b0;
        host.xfer(1'b1, CHF_ADDR_QTHR, ~s_thr);
        @(posedge MCLK);
        ce <= 1'b1;
        rd(CHF_ADDR_QTHR);
        do_reset();
        for (int a = 0; a < 6; a++) rd(8'(a));
        repeat (4) @(posedge MCLK);
        check("CMD_START", 16'(m_cmd), 16'(n_cmd));
        check("CLEAR", 16'(m_clr), 16'(n_clr));
        check("POP", 16'(m_pop), 16'(n_pop));
        check("RD_LEFT", 16'(eq.size()), 16'h0);
        check("WQ_LEFT", 16'(wq.size()), 16'h0);
        give_verdict();
    end
endmodule
`default_nettype wire
